// ---- include/alu_pkg.sv ----
/*
 * constants, enumerations and carrier structs for the cpu alu/status datapath.
 * assumes one 20 MHz core clock and a plain register port with 4-bit word index.
 */
// Behaviour
// RL1 - nibble carry from bit 3/7 by width
// RL2 - priority bits 7..5 encode levels 0..7
// RL3 - priority bits locked while nesting disabled
// RL4 - upper bit concatenates above three priority bits
// RL5 - upper bit clearable only, blocks user interrupts
// RL6 - loop flag reads repeat-in-progress, read-only
// RL7 - negative flag follows result sign
// RL8 - overflow flag marks signed arithmetic overflow
// RL9 - zero flag cleared by nonzero result
// RL10 - carry flag from result most significant bit
// RL11 - subtraction turns carries into borrow indicators
// RL12 - program window enable bit, read-write
// RL13 - unimplemented bits read zero, reset zero
// RL14 - sixteen-bit two's complement alu operations
// RL15 - byte or word width, register/memory destination
// RL16 - 17x17 multiplier with all listed modes
// RL17 - signed/unsigned 32 or 16 by 16 divide
// RL18 - quotient and remainder to first two registers
// RL19 - divisor any register, aligned dividend pair
// RL20 - one iteration per divisor bit
// RL21 - single cycle barrel shifts up to 15
// RL22 - shifts register source and register result
// RL23 - divide takes 19 cycles, cancellable anytime
// RL24 - multiply completes in one cycle
package alu_pkg;

    // ************************************************************
    // register port map
    // ************************************************************
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] STATUS_IDX = 4'h0;
    localparam logic [3:0] CONTROL_IDX = 4'h1;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_ZERO = 1;
    localparam int ST_WRAP = 2;
    localparam int ST_NEG = 3;
    localparam int ST_LOOP = 4;
    localparam int ST_PRIO_LO = 5;
    localparam int ST_PRIO_HI = 7;
    localparam int ST_NIBBLE = 8;
    localparam int CT_WINDOW = 2;
    localparam int CT_PRIO_UP = 3;
    localparam logic [2:0] PRIO_TOP = 3'h7;

    // ************************************************************
    // timing
    // ************************************************************
    localparam real CLK_PERIOD_NS = 50.0;
    localparam logic [4:0] DIV_ITER = 5'h10;
    localparam logic [4:0] DIV_CYCLES = 5'h13;

    // ************************************************************
    // operations and carriers
    // ************************************************************
    typedef enum logic [3:0] {
        OP_PASS, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
        OP_SL, OP_ASR, OP_LSR
    } alu_op_t;

    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_BYTE
    } mul_mode_t;

    typedef struct packed {
        alu_op_t op;
        logic byte_mode;
        logic to_memory;
        logic [15:0] a;
        logic [15:0] b;
        logic [3:0] amount;
    } alu_req_t;

    typedef struct packed {
        logic [15:0] data;
        logic byte_mode;
        logic to_memory;
    } alu_rsp_t;

    typedef struct packed {
        mul_mode_t mode;
        logic [15:0] a;
        logic [15:0] b;
        logic [4:0] literal;
    } mul_req_t;

    typedef struct packed {
        logic is_signed;
        logic wide;
        logic [15:0] dividend_hi;
        logic [15:0] dividend_lo;
        logic [15:0] divisor;
    } div_req_t;

endpackage

// ---- src/cpu_alu_status_datapath.sv ----
/*
 * alu, multiplier, iterative divider, barrel shifter, status and control words.
 * assumes one-cycle synchronous requests; the decoder owns writeback.
 */
`timescale 1ns/1ns
module cpu_alu_status_datapath
    import alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic nested_irq_disable,
    input wire logic loop_running_flag,
    input wire logic prio_upper_set,
    output logic [3:0] cpu_priority_level,
    output logic user_irq_disable,
    output logic program_window_enable,
    input wire logic alu_valid,
    input wire alu_req_t alu_req,
    output logic alu_rsp_valid,
    output alu_rsp_t alu_rsp,
    input wire logic mul_valid,
    input wire mul_req_t mul_req,
    output logic mul_rsp_valid,
    output logic [31:0] mul_product,
    input wire logic div_start,
    input wire logic div_cancel,
    input wire div_req_t div_req,
    output logic div_busy,
    output logic div_done,
    output logic [15:0] quotient_reg,
    output logic [15:0] remainder_reg
);

    // ************************************************************
    // state
    // ************************************************************
    logic c_q, z_q, ov_q, n_q, dc_q;
    logic [2:0] prio_q;
    logic prio_up_q, window_q;
    logic [15:0] rdata_q;
    alu_rsp_t alu_rsp_q;
    logic alu_rsp_valid_q;
    logic [31:0] mul_q;
    logic mul_valid_q;
    logic [4:0] div_cnt_q;
    logic [16:0] div_rem_q;
    logic [15:0] div_quo_q, div_dvs_q, quot_q, rem_q;
    logic div_qneg_q, div_rneg_q, div_done_q;

    // ************************************************************
    // alu adder
    // ************************************************************
    wire [15:0] op_a = alu_req.a;
    wire [15:0] op_b = alu_req.b;
    wire byte_w = alu_req.byte_mode; // RL15
    wire is_sub = (alu_req.op == OP_SUB) || (alu_req.op == OP_SUBB);
    wire is_arith = (alu_req.op == OP_ADD) || (alu_req.op == OP_ADDC) || is_sub;
    wire is_logic = (alu_req.op == OP_AND) || (alu_req.op == OP_IOR) || (alu_req.op == OP_XOR);
    wire is_shift = (alu_req.op == OP_SL) || (alu_req.op == OP_ASR) || (alu_req.op == OP_LSR);
    // subtraction is a + ~b + 1, so carries come out as inverted borrows
    wire [15:0] b_eff = is_sub ? ~op_b : op_b; // RL11
    wire carry_in = ((alu_req.op == OP_ADDC) || (alu_req.op == OP_SUBB)) ? c_q : (alu_req.op == OP_SUB);
    wire [16:0] sum_w = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, carry_in}; // RL14
    wire [8:0] sum_b = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, carry_in};
    wire [4:0] sum_n = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};

    // ************************************************************
    // barrel shifter
    // ************************************************************
    // register operands only, never memory data
    wire [15:0] sh_src_u = byte_w ? {8'h00, op_a[7:0]} : op_a; // RL22
    wire [15:0] sh_src_s = byte_w ? {{8{op_a[7]}}, op_a[7:0]} : op_a;
    wire [15:0] sh_left = sh_src_u << alu_req.amount; // RL21
    wire [15:0] sh_lright = sh_src_u >> alu_req.amount; // RL21
    wire [15:0] sh_aright = 16'($signed(sh_src_s) >>> alu_req.amount); // RL21

    // ************************************************************
    // result select and flags
    // ************************************************************
    wire [15:0] res_full =
        is_arith ? sum_w[15:0] :
        (alu_req.op == OP_AND) ? (op_a & op_b) :
        (alu_req.op == OP_IOR) ? (op_a | op_b) :
        (alu_req.op == OP_XOR) ? (op_a ^ op_b) :
        (alu_req.op == OP_SL) ? sh_left :
        (alu_req.op == OP_ASR) ? sh_aright :
        (alu_req.op == OP_LSR) ? sh_lright : op_a;
    wire [15:0] res_out = byte_w ? {8'h00, res_full[7:0]} : res_full; // RL15
    wire res_msb = byte_w ? res_full[7] : res_full[15];
    wire a_msb = byte_w ? op_a[7] : op_a[15];
    wire b_msb = byte_w ? b_eff[7] : b_eff[15];
    wire res_zero = byte_w ? (res_full[7:0] == 8'h00) : (res_full == 16'h0000);
    wire new_c = byte_w ? sum_b[8] : sum_w[16]; // RL10
    wire new_dc = byte_w ? sum_n[4] : sum_b[8]; // RL1
    wire new_ov = (a_msb == b_msb) && (res_msb != a_msb); // RL8
    wire new_n = res_msb; // RL7
    // carry-chained ops only ever clear zero, so multiword compares work
    wire z_sticky = (alu_req.op == OP_ADDC) || (alu_req.op == OP_SUBB);
    wire new_z = z_sticky ? (z_q & res_zero) : res_zero; // RL9
    wire arith_upd = alu_valid && is_arith;
    wire nz_upd = alu_valid && (is_arith || is_logic || is_shift || alu_req.op == OP_PASS);

    // ************************************************************
    // register port decode
    // ************************************************************
    wire st_sel = (reg_addr == STATUS_IDX);
    wire ct_sel = (reg_addr == CONTROL_IDX);
    wire st_wr = reg_wr && st_sel;
    wire ct_wr = reg_wr && ct_sel;
    wire [15:0] status_word = {7'h00, dc_q, prio_q, loop_running_flag, n_q, ov_q, z_q, c_q}; // RL6 RL13
    wire [15:0] control_word = {12'h000, prio_up_q, window_q, 2'h0}; // RL13
    wire [15:0] rdata_d = !reg_rd ? 16'h0000 :
        st_sel ? status_word :
        ct_sel ? control_word : 16'h0000;

    // hardware flag updates win over a software write in the same cycle
    wire c_d = arith_upd ? new_c : st_wr ? reg_wdata[ST_CARRY] : c_q; // RL10
    wire dc_d = arith_upd ? new_dc : st_wr ? reg_wdata[ST_NIBBLE] : dc_q; // RL1
    wire ov_d = arith_upd ? new_ov : st_wr ? reg_wdata[ST_WRAP] : ov_q; // RL8
    wire n_d = nz_upd ? new_n : st_wr ? reg_wdata[ST_NEG] : n_q; // RL7
    wire z_d = nz_upd ? new_z : st_wr ? reg_wdata[ST_ZERO] : z_q; // RL9
    wire [2:0] prio_d = (st_wr && !nested_irq_disable) ? reg_wdata[ST_PRIO_HI:ST_PRIO_LO] : prio_q; // RL2 RL3
    // software only clears the upper bit; the set input wins
    wire prio_up_d = prio_upper_set ? 1'b1 : (ct_wr && !reg_wdata[CT_PRIO_UP]) ? 1'b0 : prio_up_q; // RL5
    wire window_d = ct_wr ? reg_wdata[CT_WINDOW] : window_q; // RL12

    // ************************************************************
    // status and control registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {dc_q, prio_q, n_q, ov_q, z_q, c_q} <= {STATUS_RESET[8:5], STATUS_RESET[3:0]}; // RL13
            {prio_up_q, window_q} <= CONTROL_RESET[3:2];
            rdata_q <= 16'h0000;
        end else if (clk_en) begin
            {dc_q, prio_q, n_q, ov_q, z_q, c_q} <= {dc_d, prio_d, n_d, ov_d, z_d, c_d};
            {prio_up_q, window_q} <= {prio_up_d, window_d};
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign cpu_priority_level = {prio_up_q, prio_q}; // RL4
    assign user_irq_disable = prio_up_q || (prio_q == PRIO_TOP); // RL2 RL5
    assign program_window_enable = window_q; // RL12

    // ************************************************************
    // alu result
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            alu_rsp_q <= '0;
            alu_rsp_valid_q <= 1'b0;
        end else if (clk_en) begin
            alu_rsp_valid_q <= alu_valid;
            if (alu_valid) begin
                alu_rsp_q <= '{data: res_out, byte_mode: byte_w, to_memory: alu_req.to_memory}; // RL15
            end
        end
    end

    assign alu_rsp = alu_rsp_q;
    assign alu_rsp_valid = alu_rsp_valid_q;

    // ************************************************************
    // multiplier
    // ************************************************************
    wire m_byte = (mul_req.mode == MUL_BYTE);
    wire m_lit = (mul_req.mode == MUL_SLIT) || (mul_req.mode == MUL_ULIT);
    wire m_a_sgn = (mul_req.mode == MUL_SS) || (mul_req.mode == MUL_SU) || (mul_req.mode == MUL_SLIT);
    wire m_b_sgn = (mul_req.mode == MUL_SS) || (mul_req.mode == MUL_US);
    wire [15:0] m_a_src = m_byte ? {8'h00, mul_req.a[7:0]} : mul_req.a;
    wire [15:0] m_b_src = m_lit ? {11'h000, mul_req.literal} : m_byte ? {8'h00, mul_req.b[7:0]} : mul_req.b;
    // a 17th bit carries the sign or a zero, so one signed array serves every mode
    wire [16:0] m_a17 = {m_a_sgn & m_a_src[15], m_a_src}; // RL16
    wire [16:0] m_b17 = {m_b_sgn & m_b_src[15], m_b_src}; // RL16
    wire [33:0] m_prod = 34'($signed(m_a17) * $signed(m_b17)); // RL16

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mul_q <= 32'h00000000;
            mul_valid_q <= 1'b0;
        end else if (clk_en) begin
            mul_valid_q <= mul_valid; // RL24
            if (mul_valid) begin
                mul_q <= m_prod[31:0]; // RL24
            end
        end
    end

    assign mul_product = mul_q;
    assign mul_rsp_valid = mul_valid_q;

    // ************************************************************
    // divider
    // ************************************************************
    // high word is the odd register of the pair
    wire [31:0] dvd_raw = div_req.wide ? {div_req.dividend_hi, div_req.dividend_lo} : // RL19
        div_req.is_signed ? {{16{div_req.dividend_lo[15]}}, div_req.dividend_lo} :
        {16'h0000, div_req.dividend_lo}; // RL17
    wire dvd_neg = div_req.is_signed && dvd_raw[31];
    wire dvs_neg = div_req.is_signed && div_req.divisor[15];
    wire [31:0] dvd_abs = dvd_neg ? (~dvd_raw + 32'h00000001) : dvd_raw;
    wire [15:0] dvs_abs = dvs_neg ? (~div_req.divisor + 16'h0001) : div_req.divisor;
    wire div_accept = div_start && !div_busy && !div_cancel;
    wire div_iter = (div_cnt_q != 5'h00) && (div_cnt_q <= DIV_ITER);
    wire div_last = (div_cnt_q == DIV_CYCLES);
    // restoring step; the partial remainder never exceeds 17 bits
    wire [17:0] trial = {1'b0, div_rem_q[15:0], div_quo_q[15]} - {2'h0, div_dvs_q};
    wire trial_ok = !trial[17];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_cnt_q <= 5'h00;
            div_rem_q <= 17'h00000;
            div_quo_q <= 16'h0000;
            div_dvs_q <= 16'h0000;
            {div_qneg_q, div_rneg_q, div_done_q} <= 3'h0;
        end else if (clk_en) begin
            div_done_q <= div_last && !div_cancel;
            if (div_cancel) begin
                div_cnt_q <= 5'h00; // RL23
            end else if (div_accept) begin
                div_cnt_q <= 5'h01;
                div_rem_q <= {1'b0, dvd_abs[31:16]};
                div_quo_q <= dvd_abs[15:0];
                div_dvs_q <= dvs_abs;
                div_qneg_q <= dvd_neg ^ dvs_neg;
                div_rneg_q <= dvd_neg;
            end else if (div_last) begin
                div_cnt_q <= 5'h00; // RL23
            end else if (div_cnt_q != 5'h00) begin
                div_cnt_q <= div_cnt_q + 5'h01;
                if (div_iter) begin
                    div_rem_q <= trial_ok ? trial[16:0] : {div_rem_q[15:0], div_quo_q[15]}; // RL20
                    div_quo_q <= {div_quo_q[14:0], trial_ok}; // RL20
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            quot_q <= 16'h0000;
            rem_q <= 16'h0000;
        end else if (clk_en && div_last && !div_cancel) begin
            quot_q <= div_qneg_q ? (~div_quo_q + 16'h0001) : div_quo_q; // RL18
            rem_q <= div_rneg_q ? (~div_rem_q[15:0] + 16'h0001) : div_rem_q[15:0]; // RL18
        end
    end

    assign div_busy = (div_cnt_q != 5'h00);
    assign div_done = div_done_q;
    assign quotient_reg = quot_q;
    assign remainder_reg = rem_q;

    // ************************************************************
    // checks
    // ************************************************************
    logic [4:0] div_age_q;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_age_q <= 5'h00;
        end else if (clk_en) begin
            if (div_accept) begin
                div_age_q <= 5'h00;
            end else if (div_age_q != 5'h1F) begin
                div_age_q <= div_age_q + 5'h01;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_status_unused_zero: assert property (clk_en && reg_rd && st_sel |=> reg_rdata[15:9] == 7'h00) // RL13
        else $error("status word unused bits not zero");
    chk_control_unused_zero: assert property (clk_en && reg_rd && ct_sel |=>
        reg_rdata[15:4] == 12'h000 && reg_rdata[1:0] == 2'h0) // RL13
        else $error("control word unused bits not zero");
    chk_prio_write_lands: assert property (clk_en && st_wr && !nested_irq_disable |=>
        cpu_priority_level[2:0] == $past(reg_wdata[7:5])) // RL2
        else $error("priority write not taken");
    chk_prio_locked: assert property (clk_en && nested_irq_disable |=> $stable(prio_q)) // RL3
        else $error("priority bits changed while locked");
    chk_upper_noset: assert property (clk_en && !prio_upper_set && !prio_up_q |=> !cpu_priority_level[3]) // RL5
        else $error("upper priority bit set by software");
    chk_upper_blocks: assert property (cpu_priority_level[3] |-> user_irq_disable && cpu_priority_level >= 4'h8) // RL4
        else $error("upper priority bit does not block interrupts");
    chk_loop_flag_read: assert property (clk_en && reg_rd && st_sel |=> reg_rdata[4] == $past(loop_running_flag)) // RL6
        else $error("loop flag read wrong");
    chk_zero_clear: assert property (clk_en && alu_valid && !res_zero |=> !z_q) // RL9
        else $error("zero flag not cleared by nonzero result");
    chk_word_add_carry: assert property (clk_en && alu_valid && alu_req.op == OP_ADD && !byte_w |=>
        c_q == ($past(op_a) > ~$past(op_b))) // RL10
        else $error("carry flag wrong after add");
    chk_window_write: assert property (clk_en && ct_wr |=> program_window_enable == $past(reg_wdata[2])) // RL12
        else $error("window enable not written");
    chk_mul_one_cycle: assert property (clk_en && mul_valid |=> mul_rsp_valid) // RL24
        else $error("multiply result late");
    chk_div_latency: assert property (div_done |-> div_age_q == DIV_CYCLES) // RL23
        else $error("divide did not take 19 cycles");

    cov_divide_done: cover property (div_accept ##[1:40] div_done);
    cov_upper_cleared: cover property (prio_up_q ##1 !prio_up_q);
    cov_zero_sticky: cover property (clk_en && alu_valid && z_sticky && res_zero && z_q);

endmodule

// ---- bench/decoder_model.sv ----
/*
 * decoder and working register model: one-cycle alu, multiply, divide requests.
 * assumes one calling process, one request at a time.
 */
`timescale 1ns/1ns
module decoder_model
    import alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic div_done,
    input wire logic [15:0] quotient_reg,
    input wire logic [15:0] remainder_reg,
    output logic alu_valid,
    output alu_req_t alu_req,
    output logic mul_valid,
    output mul_req_t mul_req,
    output logic div_start,
    output logic div_cancel,
    output div_req_t div_req
);
    // ************************************************************
    // working registers and request tasks
    // ************************************************************
    logic [15:0] w [0:15];
    initial begin
        {alu_valid, alu_req, mul_valid, mul_req, div_start, div_cancel, div_req} = '0;
    end
    // only the done pulse writes back, so cancel leaves the pair
    always @(posedge core_clk) begin
        if (div_done === 1'b1) begin
            w[0] <= quotient_reg;
            w[1] <= remainder_reg;
        end
    end
    task automatic alu_op(input alu_op_t op, input logic bm, input logic [15:0] a, b, input logic [3:0] amt);
        @(posedge core_clk);
        alu_valid <= 1'b1;
        alu_req <= '{op: op, byte_mode: bm, to_memory: 1'b0, a: a, b: b, amount: amt};
        @(posedge core_clk);
        alu_valid <= 1'b0;
    endtask
    task automatic mul_op(input mul_mode_t m, input logic [15:0] a, b, input logic [4:0] lit);
        @(posedge core_clk);
        mul_valid <= 1'b1;
        mul_req <= '{mode: m, a: a, b: b, literal: lit};
        @(posedge core_clk);
        mul_valid <= 1'b0;
    endtask
    // aligned dividend pair, any divisor register
    task automatic div_op(input logic s, wd, input int m, n);
        @(posedge core_clk);
        div_start <= 1'b1;
        div_req <= '{is_signed: s, wide: wd, dividend_hi: w[2*m+1], dividend_lo: w[2*m], divisor: w[n]};
        @(posedge core_clk);
        div_start <= 1'b0;
    endtask
    task automatic cancel();
        @(posedge core_clk);
        div_cancel <= 1'b1;
        @(posedge core_clk);
        div_cancel <= 1'b0;
    endtask
endmodule

// ---- bench/cpu_alu_status_datapath_tb_top.sv ----
/*
 * self-checking bench: registers, alu table, multiply, divide, cancel.
 * assumes decoder_model drives requests; clk_en held high.
 */
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; $display("ERROR %s expected %h seen %h", what, exp, got); end end
module cpu_alu_status_datapath_tb_top
    import alu_pkg::*;
;
    // ************************************************************
    // signals, tables and tasks
    // ************************************************************
    typedef struct {alu_op_t op; logic bm; logic [15:0] a, b; logic [3:0] amt; logic [15:0] data, st;} alu_row_t;
    logic core_clk = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic nested_irq_disable = 0, loop_running_flag = 0, prio_upper_set = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, quotient_reg, remainder_reg;
    logic [3:0] cpu_priority_level;
    logic user_irq_disable, program_window_enable, alu_valid, alu_rsp_valid, mul_valid, mul_rsp_valid;
    logic div_start, div_cancel, div_busy, div_done;
    logic [31:0] mul_product;
    alu_req_t alu_req;
    alu_rsp_t alu_rsp;
    mul_req_t mul_req;
    div_req_t div_req;
    int errors = 0, tests_run = 0, cycles = 0, lat;
    alu_row_t rows [14] = '{
        '{OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 4'h0, 16'h0000, 16'h0103}, '{OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 4'h0, 16'h8000, 16'h010C},
        '{OP_SUB, 1'b0, 16'h0000, 16'h0001, 4'h0, 16'hFFFF, 16'h0008}, '{OP_SUB, 1'b1, 16'h0005, 16'h0003, 4'h0, 16'h0002, 16'h0101},
        '{OP_AND, 1'b0, 16'hF0F0, 16'h0F0F, 4'h0, 16'h0000, 16'h0103}, '{OP_XOR, 1'b0, 16'h8000, 16'h0001, 4'h0, 16'h8001, 16'h0109},
        '{OP_IOR, 1'b0, 16'h1200, 16'h0034, 4'h0, 16'h1234, 16'h0101}, '{OP_SL, 1'b0, 16'h0001, 16'h0000, 4'hF, 16'h8000, 16'h0109},
        '{OP_ASR, 1'b0, 16'h8000, 16'h0000, 4'hF, 16'hFFFF, 16'h0109}, '{OP_LSR, 1'b0, 16'h8000, 16'h0000, 4'hF, 16'h0001, 16'h0101},
        '{OP_ADDC, 1'b0, 16'h0001, 16'h0001, 4'h0, 16'h0003, 16'h0000}, '{OP_ADD, 1'b1, 16'h0080, 16'h0080, 4'h0, 16'h0000, 16'h0007},
        '{OP_SUBB, 1'b0, 16'h0005, 16'h0005, 4'h0, 16'h0000, 16'h0103}, '{OP_PASS, 1'b0, 16'h8000, 16'h0000, 4'h0, 16'h8000, 16'h0109}};
    logic [31:0] mul_exp [7] = '{32'hFFFFFFFE, 32'h0001FFFE, 32'hFFFFFFFE, 32'h0001FFFE, 32'hFFFFFFE1, 32'h001EFFE1, 32'h000001FE};

    cpu_alu_status_datapath dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nested_irq_disable(nested_irq_disable), .loop_running_flag(loop_running_flag), .prio_upper_set(prio_upper_set),
        .cpu_priority_level(cpu_priority_level), .user_irq_disable(user_irq_disable),
        .program_window_enable(program_window_enable), .alu_valid(alu_valid), .alu_req(alu_req),
        .alu_rsp_valid(alu_rsp_valid), .alu_rsp(alu_rsp), .mul_valid(mul_valid), .mul_req(mul_req),
        .mul_rsp_valid(mul_rsp_valid), .mul_product(mul_product), .div_start(div_start), .div_cancel(div_cancel),
        .div_req(div_req), .div_busy(div_busy), .div_done(div_done), .quotient_reg(quotient_reg),
        .remainder_reg(remainder_reg));
    decoder_model far (.core_clk(core_clk), .div_done(div_done), .quotient_reg(quotient_reg),
        .remainder_reg(remainder_reg), .alu_valid(alu_valid), .alu_req(alu_req), .mul_valid(mul_valid),
        .mul_req(mul_req), .div_start(div_start), .div_cancel(div_cancel), .div_req(div_req));

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand one cycle only
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHECK(what, exp, reg_rdata)
    endtask
    task automatic wait_done();
        lat = 0;
        while (div_done !== 1'b1 && lat < 40) begin
            @(posedge core_clk);
            #1;
            lat++;
        end
        @(posedge core_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("ERROR timeout expected done seen hang");
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        chk_reg(STATUS_IDX, 16'h0000, "status reset");
        chk_reg(CONTROL_IDX, 16'h0000, "control reset");
        reg_write(CONTROL_IDX, 16'hFFFF);
        chk_reg(CONTROL_IDX, 16'h0004, "control ones");
        `CHECK("window", 1'b1, program_window_enable)
        @(posedge core_clk) prio_upper_set <= 1'b1;
        @(posedge core_clk) prio_upper_set <= 1'b0;
        chk_reg(CONTROL_IDX, 16'h000C, "upper set");
        `CHECK("level upper", 4'h8, cpu_priority_level)
        `CHECK("irq off upper", 1'b1, user_irq_disable)
        reg_write(CONTROL_IDX, 16'h0000);
        chk_reg(CONTROL_IDX, 16'h0000, "upper cleared");
        reg_write(STATUS_IDX, 16'hFFFF);
        loop_running_flag <= 1'b1;
        chk_reg(STATUS_IDX, 16'h01FF, "status ones");
        `CHECK("level top", 4'h7, cpu_priority_level)
        `CHECK("irq off top", 1'b1, user_irq_disable)
        loop_running_flag <= 1'b0;
        nested_irq_disable <= 1'b1;
        reg_write(STATUS_IDX, 16'h0000);
        chk_reg(STATUS_IDX, 16'h00E0, "prio locked");
        nested_irq_disable <= 1'b0;
        reg_write(STATUS_IDX, 16'h00A0);
        chk_reg(STATUS_IDX, 16'h00A0, "prio five");
        `CHECK("level five", 4'h5, cpu_priority_level)
        `CHECK("irq on", 1'b0, user_irq_disable)
        chk_reg(4'h5, 16'h0000, "unmapped");
        reg_write(STATUS_IDX, 16'h0000);
        foreach (rows[i]) begin
            far.alu_op(rows[i].op, rows[i].bm, rows[i].a, rows[i].b, rows[i].amt);
            #1;
            `CHECK("alu valid", 1'b1, alu_rsp_valid)
            `CHECK("alu rsp", {rows[i].data, rows[i].bm, 1'b0}, alu_rsp)
            chk_reg(STATUS_IDX, rows[i].st, "alu flags");
        end
        for (int i = 0; i < 7; i++) begin
            far.mul_op(mul_mode_t'(i), 16'hFFFF, 16'h0002, 5'h1F);
            #1;
            `CHECK("mul valid", 1'b1, mul_rsp_valid)
            `CHECK("mul product", mul_exp[i], mul_product)
        end
        far.w[2] = 16'hFFF9;
        far.w[4] = 16'h0002;
        far.w[6] = 16'h0000;
        far.w[7] = 16'h0001;
        far.w[9] = 16'h0003;
        far.div_op(1'b1, 1'b0, 1, 4);
        wait_done();
        `CHECK("div cycles", 19, lat)
        `CHECK("signed quotient", 16'hFFFD, far.w[0])
        `CHECK("signed remainder", 16'hFFFF, far.w[1])
        // start while busy is dropped
        far.div_op(1'b0, 1'b1, 3, 9);
        far.div_op(1'b1, 1'b0, 1, 4);
        wait_done();
        `CHECK("wide quotient", 16'h5555, far.w[0])
        `CHECK("wide remainder", 16'h0001, far.w[1])
        far.div_op(1'b1, 1'b0, 1, 4);
        repeat (3) @(posedge core_clk);
        far.cancel();
        repeat (25) begin
            @(posedge core_clk);
            #1;
            `CHECK("no done", 1'b0, div_done)
        end
        `CHECK("idle after cancel", 1'b0, div_busy)
        `CHECK("kept quotient", 16'h5555, quotient_reg)
        summarize();
    end
endmodule
